// File: src/fpc_fan_pwm_config.sv
// Contract
// (R1) In sole-input mode, limit high bits 4:0 are reserved; else limit bits.
// (R2) In sole-input mode, limit high bits 7:5 pick the converter input.
// (R3) High-limit alert only when value strictly exceeds high limit.
// (R4) Low-limit alert when value is at or below low limit.
// (R5) Three-bit spin field picks startup window: none, 100ms up to 4s.
// (R6) No speed pulse in window: count reads all ones, fan fault flagged.
// (R7) Polarity clear: full duty is high; set: output inverted.
// (R8) Software never writes reserved bit three of channel config.
// (R9) Codes 000,001,010: auto control from remote1, local, remote2.
// (R10) Code 011 full speed (default); code 100 disables output.
// (R11) Code 101 max of local and remote2; 110 max of all three.
// (R12) Code 111 manual: duty registers become software writable.
// (R13) Lock bit set makes channel config registers read-only.
// (R14) Fan count above minimum limit by one or more sets fan fault.
// (R15) Disabled channel holds zero-duty level, polarity applied.
//
// Added by the designer: the APB register port.
`include "fpc_params.svh"
module fpc_fan_pwm_config #(
	parameter int CLK_KHZ = `FPC_CLK_KHZ
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic [2:0]              fan_speed_pulse,
	input  wire fpc_pkg::fpc_auto_duty_s auto_duty,
	input  wire logic [15:0]             value_meas,
	input  wire logic [15:0]             value_high_lim,
	input  wire logic [15:0]             value_low_lim,
	input  wire logic [15:0]             fan1_speed_count,
	output logic [2:0]                   pwm_out,
	output logic [2:0]                   sole_input_select,
	output logic                         sole_input_mode,
	output logic                         limit_alert,
	output logic                         irq
);
	localparam int TW = 28;
	localparam logic [TW-1:0] CYC_MS = TW'(CLK_KHZ);

	fpc_pkg::fpc_ch_cfg_s cfg_q [3];
	logic [7:0]  duty_q [3];
	logic [7:0]  lim_lo_q, lim_hi_q, cfg1_q, cfg2_q, stat2_q, mask2_q;
	logic [15:0] cnt1_q;
	logic [7:0]  pwm_cnt_q;
	logic [2:0]  sp_s1_q, sp_s2_q, sp_s3_q;
	logic [TW-1:0] spin_tmr_q [3];
	logic [2:0]  spun_q, fault_ev;
	logic        fault_cnt;
	logic        wr, rd, locked;
	logic [7:0]  rdat;
	logic [7:0]  eff_duty [3];
	logic [9:0]  reg_idx;

	// Word index of the access; low two address bits ignored
	assign reg_idx = paddr[11:2];
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign locked = cfg1_q[`FPC_CFG1_LOCK];
	assign sole_input_mode = cfg2_q[`FPC_CFG2_SOLE];

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; reset to the pulled-up idle level so no false edge follows reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sp_s1_q <= 3'h7;
			sp_s2_q <= 3'h7;
			sp_s3_q <= 3'h7;
		end else begin
			sp_s1_q <= fan_speed_pulse;
			sp_s2_q <= sp_s1_q;
			sp_s3_q <= sp_s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Plain registers; limits and config words never locked
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lim_lo_q <= `FPC_RST_LIM;
			lim_hi_q <= `FPC_RST_LIM;
			cfg1_q   <= 8'h00;
			cfg2_q   <= 8'h00;
			mask2_q  <= 8'h00;
		end else if (wr) begin
			unique case (reg_idx)
				`FPC_ADDR_LIM_LO: lim_lo_q <= pwdata[7:0];
				`FPC_ADDR_LIM_HI: begin
					lim_hi_q[7:5] <= pwdata[7:5]; // (R2)
					if (!sole_input_mode)
						lim_hi_q[4:0] <= pwdata[4:0]; // (R1)
				end
				// Lock is sticky until reset
				`FPC_ADDR_CFG1: cfg1_q <= pwdata[7:0] | {7'h00, locked};
				`FPC_ADDR_CFG2:  cfg2_q  <= pwdata[7:0];
				`FPC_ADDR_MASK2: mask2_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	assign sole_input_select = sole_input_mode ? lim_hi_q[7:5] : 3'h0; // (R2)

	////////////////////////////////////////////////////////////////////////
	// Channel config and manual duty registers
	for (genvar i = 0; i < 3; i++) begin : g_ch
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				cfg_q[i] <= `FPC_RST_CH_CFG;
			end else if (wr && !locked && reg_idx == `FPC_ADDR_CH1_CFG + 10'(i)) begin // (R13)
				cfg_q[i] <= pwdata[7:0];
				cfg_q[i].res <= cfg_q[i].res; // (R8) reserved bit not stored
			end
		end

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				duty_q[i] <= 8'h00;
			end else if (wr && reg_idx == `FPC_ADDR_DUTY1 + 10'(i)
					&& cfg_q[i].fan_behaviour_select == fpc_pkg::FPC_BH_MAN) begin // (R12)
				duty_q[i] <= pwdata[7:0];
			end
		end

		// Duty chosen by behaviour code
		always_comb begin
			unique case (cfg_q[i].fan_behaviour_select)
				fpc_pkg::FPC_BH_REM1:  eff_duty[i] = auto_duty.rem1; // (R9)
				fpc_pkg::FPC_BH_LOCAL: eff_duty[i] = auto_duty.local_t; // (R9)
				fpc_pkg::FPC_BH_REM2:  eff_duty[i] = auto_duty.rem2; // (R9)
				fpc_pkg::FPC_BH_FULL:  eff_duty[i] = `FPC_FULL_DUTY; // (R10)
				fpc_pkg::FPC_BH_OFF:   eff_duty[i] = 8'h00; // (R10) (R15)
				fpc_pkg::FPC_BH_MAXLR: eff_duty[i] = (auto_duty.local_t > auto_duty.rem2)
					? auto_duty.local_t : auto_duty.rem2; // (R11)
				fpc_pkg::FPC_BH_MAXA: begin
					eff_duty[i] = (auto_duty.local_t > auto_duty.rem2)
						? auto_duty.local_t : auto_duty.rem2; // (R11)
					if (auto_duty.rem1 > eff_duty[i])
						eff_duty[i] = auto_duty.rem1;
				end
				fpc_pkg::FPC_BH_MAN:   eff_duty[i] = duty_q[i]; // (R12)
			endcase
		end

		// Output registered; full duty holds high, zero holds low, then invert
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				pwm_out[i] <= 1'b0;
			end else begin
				pwm_out[i] <= ((eff_duty[i] == `FPC_FULL_DUTY) || (pwm_cnt_q < eff_duty[i]))
					^ cfg_q[i].output_polarity_invert; // (R7) (R15)
			end
		end

		// Spin-up window: restarts when channel leaves disabled, ends on first pulse
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				spin_tmr_q[i] <= '0;
				spun_q[i] <= 1'b0;
			end else if (cfg_q[i].fan_behaviour_select == fpc_pkg::FPC_BH_OFF
					|| cfg_q[i].spin == 3'h0) begin
				spin_tmr_q[i] <= '0;
				spun_q[i] <= 1'b0;
			end else if (sp_s2_q[i] && !sp_s3_q[i]) begin
				spun_q[i] <= 1'b1;
			end else if (!spun_q[i] && spin_tmr_q[i] != spin_limit(cfg_q[i].spin)) begin
				spin_tmr_q[i] <= spin_tmr_q[i] + TW'(1);
			end
		end
		assign fault_ev[i] = !spun_q[i] && cfg_q[i].spin != 3'h0
			&& cfg_q[i].fan_behaviour_select != fpc_pkg::FPC_BH_OFF
			&& spin_tmr_q[i] == spin_limit(cfg_q[i].spin); // (R5) (R6)
	end

	// Startup window in clock cycles
	function automatic logic [TW-1:0] spin_limit(input logic [2:0] code);
		logic [TW-1:0] ms;
		ms = '0;
		unique case (code) // (R5)
			3'h0: ms = '0;
			3'h1: ms = TW'(`FPC_T1_MS);
			3'h2: ms = TW'(`FPC_T2_MS);
			3'h3: ms = TW'(`FPC_T3_MS);
			3'h4: ms = TW'(`FPC_T4_MS);
			3'h5: ms = TW'(`FPC_T5_MS);
			3'h6: ms = TW'(`FPC_T6_MS);
			3'h7: ms = TW'(`FPC_T7_MS);
		endcase
		return TW'(ms * CYC_MS);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Free-running duty counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pwm_cnt_q <= 8'h00;
		else
			pwm_cnt_q <= (pwm_cnt_q == 8'hFE) ? 8'h00 : pwm_cnt_q + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////
	// Fan 1 count: forced to all ones on spin-up failure
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cnt1_q <= 16'h0000;
		else if (fault_ev[0])
			cnt1_q <= `FPC_CNT_ALL1; // (R6)
		else if (spun_q[0] || cfg_q[0].spin == 3'h0)
			cnt1_q <= fan1_speed_count; // No timeout: count always follows
	end

	// Minimum-speed check; high byte bits 4:0 ignored in sole-input mode
	assign fault_cnt = cnt1_q > {lim_hi_q[7:5],
		sole_input_mode ? 5'h00 : lim_hi_q[4:0], lim_lo_q}; // (R14)

	// Generic limit compare
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			limit_alert <= 1'b0;
		else
			limit_alert <= (value_meas > value_high_lim) // (R3)
				|| (value_meas <= value_low_lim); // (R4)
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky fan faults: bits 2:0 channels, set wins over read-clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			stat2_q <= 8'h00;
		else
			stat2_q <= ((rd && reg_idx == `FPC_ADDR_STAT2) ? 8'h00 : stat2_q)
				| {5'h00, fault_ev[2:1], fault_ev[0] | fault_cnt}; // (R6) (R14)
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(stat2_q & mask2_q);
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux
	always_comb begin
		rdat = 8'h00;
		pslverr = 1'b0;
		unique case (reg_idx)
			`FPC_ADDR_LIM_LO:  rdat = lim_lo_q;
			`FPC_ADDR_LIM_HI:  rdat = {lim_hi_q[7:5], sole_input_mode ? 5'h00 : lim_hi_q[4:0]}; // (R1)
			`FPC_ADDR_CH1_CFG: rdat = cfg_q[0];
			`FPC_ADDR_CH2_CFG: rdat = cfg_q[1];
			`FPC_ADDR_CH3_CFG: rdat = cfg_q[2];
			`FPC_ADDR_DUTY1:   rdat = eff_duty[0];
			`FPC_ADDR_DUTY2:   rdat = eff_duty[1];
			`FPC_ADDR_DUTY3:   rdat = eff_duty[2];
			`FPC_ADDR_CFG1:    rdat = cfg1_q;
			`FPC_ADDR_CFG2:    rdat = cfg2_q;
			`FPC_ADDR_STAT2:   rdat = stat2_q;
			`FPC_ADDR_MASK2:   rdat = mask2_q;
			`FPC_ADDR_CNT1:    rdat = cnt1_q[7:0];
			`FPC_ADDR_CNT1 + 10'h001: rdat = cnt1_q[15:8];
			default:           pslverr = psel && penable;
		endcase
	end

	// Read data held in a flop for the access phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= {24'h000000, rdat};
	end
endmodule

// File: src/fpc_params.svh
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH
// Register indices; each register is one APB word, byte address is four times the index
`define FPC_ADDR_LIM_HI   10'h055
`define FPC_ADDR_CH1_CFG  10'h05C
`define FPC_ADDR_CH2_CFG  10'h05D
`define FPC_ADDR_CH3_CFG  10'h05E
// Indices of our own
`define FPC_ADDR_LIM_LO   10'h054
`define FPC_ADDR_CFG1     10'h040
`define FPC_ADDR_CFG2     10'h073
`define FPC_ADDR_DUTY1    10'h030
`define FPC_ADDR_DUTY2    10'h031
`define FPC_ADDR_DUTY3    10'h032
`define FPC_ADDR_CNT1     10'h028
`define FPC_ADDR_STAT2    10'h042
`define FPC_ADDR_MASK2    10'h075
// Reset values
`define FPC_RST_LIM       8'hFF
`define FPC_RST_CH_CFG    8'h62
// Field positions
`define FPC_CFG1_LOCK     0
`define FPC_CFG2_SOLE     6
`define FPC_CH_INV        4
`define FPC_CH_RES        3
// Startup timeouts in ms
`define FPC_T1_MS  100
`define FPC_T2_MS  250
`define FPC_T3_MS  400
`define FPC_T4_MS  667
`define FPC_T5_MS  1000
`define FPC_T6_MS  2000
`define FPC_T7_MS  4000
`define FPC_CLK_KHZ 50000
`define FPC_FULL_DUTY 8'hFF
`define FPC_CNT_ALL1  16'hFFFF
`endif

// File: src/fpc_pkg.sv
package fpc_pkg;
	typedef enum logic [2:0] {
		FPC_BH_REM1  = 3'b000,
		FPC_BH_LOCAL = 3'b001,
		FPC_BH_REM2  = 3'b010,
		FPC_BH_FULL  = 3'b011,
		FPC_BH_OFF   = 3'b100,
		FPC_BH_MAXLR = 3'b101,
		FPC_BH_MAXA  = 3'b110,
		FPC_BH_MAN   = 3'b111
	} fpc_fan_behaviour_select_e;

	typedef struct packed {
		fpc_fan_behaviour_select_e  fan_behaviour_select;
		logic       output_polarity_invert;
		logic       res;
		logic [2:0] spin;
	} fpc_ch_cfg_s;

	typedef struct packed {
		logic [7:0] rem1;
		logic [7:0] local_t;
		logic [7:0] rem2;
	} fpc_auto_duty_s;
endpackage

// File: testbench/fpc_checker.sv
module fpc_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [15:0] value_meas,
	input wire logic [15:0] value_high_lim,
	input wire logic [15:0] value_low_lim,
	input wire logic [2:0]  sole_input_select,
	input wire logic        sole_input_mode,
	input wire logic        limit_alert
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	// Compare result lands one cycle after its inputs
	hi_alert_a: assert property (value_meas > value_high_lim |=> limit_alert) else $error("high alert missing");
	lo_alert_a: assert property (value_meas <= value_low_lim |=> limit_alert) else $error("low alert missing");
	no_alert_a: assert property (value_meas <= value_high_lim && value_meas > value_low_lim |=> !limit_alert)
		else $error("alert inside limits");
	// Select must read zero outside sole-input mode
	sole_zero_a: assert property (!sole_input_mode |-> sole_input_select == 3'h0) else $error("select leaks");
	sole_write_a: assert property ($changed(sole_input_mode) |-> $past(psel && penable && pwrite))
		else $error("mode changed without write");
	ready_high_a: assert property (pready) else $error("wait state seen");
	err_phase_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
	rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
	cover property (limit_alert);
	cover property (pslverr);
	cover property (sole_input_mode);
endmodule
bind fpc_fan_pwm_config fpc_checker u_chk (.clk, .rst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
	.value_meas, .value_high_lim, .value_low_lim, .sole_input_select, .sole_input_mode, .limit_alert);

// File: testbench/fpc_fan_model.sv
module fpc_fan_model #(
	parameter int HALF = 7
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic stall,
	output logic      tach
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// Stalled rotor gives no edges; pull-up keeps tach high
	always @(posedge clk or posedge rst) begin
		if (rst || stall) begin
			cnt  <= 0;
			tach <= 1'b1;
		end else begin
			cnt <= (cnt == HALF) ? 0 : cnt + 1;
			if (cnt == HALF)
				tach <= ~tach;
		end
	end
endmodule

// File: testbench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [11:0]             paddr = '0;
	logic [31:0]             pwdata = '0, prdata, rd;
	logic                    pready, pslverr, sole_input_mode, limit_alert, irq;
	logic [2:0]              stall = '0, fan_speed_pulse, pwm_out, sole_input_select;
	fpc_pkg::fpc_auto_duty_s auto_duty = 24'h402010;
	logic [15:0]             value_meas = '0, value_high_lim = '0, value_low_lim = '0, fan1_speed_count = '0;
	int                      n_fail = 0, total_checks = 0;
	always #10 clk = ~clk;
	// Short spin windows: one cycle per ms
	fpc_fan_pwm_config #(.CLK_KHZ(1)) dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .fan_speed_pulse, .auto_duty, .value_meas, .value_high_lim, .value_low_lim, .fan1_speed_count,
		.pwm_out, .sole_input_select, .sole_input_mode, .limit_alert, .irq);
	fpc_fan_model u_fan[2:0] (.clk, .rst, .stall, .tach(fan_speed_pulse));
	////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask
	// One APB transfer; an idle edge first avoids double drives
	task automatic bus(logic w, logic [11:0] a, logic [7:0] d);
		int i;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 50) begin
			n_fail++;
			complete_run();
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(string n, logic [11:0] a, logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(n, {24'h000000, e}, rd);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset();
		rdchk("limit high", 12'h154, 8'hFF);
		rdchk("ch1 cfg", 12'h170, 8'h62);
		rdchk("ch2 cfg", 12'h174, 8'h62);
		rdchk("ch3 cfg", 12'h178, 8'h62);
		rdchk("unmapped", 12'h3FC, 8'h00);
		chk("unmapped err", 32'h1, err);
	endtask
	task automatic t_alert();
		logic [15:0] mv[4] = '{16'h0100, 16'h0101, 16'h0010, 16'h0011};
		logic [3:0]  ex = 4'b0110;
		value_high_lim <= 16'h0100;
		value_low_lim  <= 16'h0010;
		for (int k = 0; k < 4; k++) begin
			value_meas <= mv[k];
			cyc(3);
			chk("limit alert", ex[k], limit_alert);
		end
	endtask
	// Full and off, each polarity; bit three is never written
	task automatic t_drive();
		logic [7:0] cf[4] = '{8'h60, 8'h70, 8'h80, 8'h90};
		logic [3:0] lv = 4'b1001;
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, 12'h170, cf[k]);
			cyc(130);
			chk("pwm level", lv[k], pwm_out[0]);
			rdchk("ch1 cfg", 12'h170, cf[k]);
		end
	endtask
	// Duty writes only stick in manual mode
	task automatic t_mode();
		logic [2:0] cd[7] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h3, 3'h7};
		logic [7:0] ex[7] = '{8'h40, 8'h20, 8'h10, 8'h20, 8'h40, 8'hFF, 8'h5A};
		for (int k = 0; k < 7; k++) begin
			bus(1'b1, 12'h170, {cd[k], 5'h00});
			bus(1'b1, 12'h0C0, 8'h5A);
			rdchk("duty", 12'h0C0, ex[k]);
		end
	endtask
	task automatic t_sole();
		bus(1'b1, 12'h1CC, 8'h40);
		bus(1'b1, 12'h154, 8'hA5);
		rdchk("limit high", 12'h154, 8'hA0);
		chk("sole select", 32'h5, sole_input_select);
		bus(1'b1, 12'h1CC, 8'h00);
		bus(1'b1, 12'h154, 8'hA5);
		rdchk("limit high", 12'h154, 8'hA5);
		chk("sole select", 32'h0, sole_input_select);
	endtask
	// Limit 0x0010: equal passes, one above faults; irq masked then raised
	task automatic t_fan();
		bus(1'b1, 12'h150, 8'h10);
		bus(1'b1, 12'h154, 8'h00);
		fan1_speed_count <= 16'h0010;
		cyc(5);
		bus(1'b0, 12'h108, 8'h00);
		rdchk("fan status", 12'h108, 8'h00);
		fan1_speed_count <= 16'h0011;
		cyc(5);
		chk("irq masked", 32'h0, irq);
		bus(1'b1, 12'h1D4, 8'h01);
		cyc(2);
		chk("irq", 32'h1, irq);
		fan1_speed_count <= 16'h0010;
		rdchk("fan status", 12'h108, 8'h01);
		cyc(2);
		chk("irq cleared", 32'h0, irq);
	endtask
	// Stalled fan: no fault before window end, fault after
	task automatic t_spin();
		int tw[7] = '{100, 250, 400, 667, 1000, 2000, 4000};
		bus(1'b1, 12'h150, 8'hFF);
		bus(1'b1, 12'h154, 8'hFF);
		stall <= 3'h1;
		for (int k = 0; k < 7; k++) begin
			bus(1'b1, 12'h170, 8'h60);
			bus(1'b0, 12'h108, 8'h00);
			bus(1'b1, 12'h170, 8'h61 + k[7:0]);
			cyc(tw[k] - 10);
			rdchk("early fault", 12'h108, 8'h00);
			cyc(20);
			rdchk("spin fault", 12'h108, 8'h01);
		end
		rdchk("count low", 12'h0A0, 8'hFF);
		rdchk("count high", 12'h0A4, 8'hFF);
		stall <= 3'h0;
	endtask
	task automatic t_lock();
		bus(1'b1, 12'h100, 8'h01);
		bus(1'b1, 12'h174, 8'h80);
		rdchk("locked cfg", 12'h174, 8'h62);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		cyc(2);
		rst <= 1'b0;
		t_reset();
		t_alert();
		t_drive();
		t_mode();
		t_sole();
		t_fan();
		t_spin();
		t_lock();
		complete_run();
	end
endmodule
